// >>> hdl/sgw_pkg.sv
// constants of the configuration port, gpio port and watchdog
package sgw_pkg;

  // ----------------------------------------------------------------
  // host i/o port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PORT_A  = 16'h002e; // config_index_port, primary
  localparam logic [15:0] DAT_PORT_A  = 16'h002f; // config_data_port, primary
  localparam logic [15:0] IDX_PORT_B  = 16'h004e; // config_index_port, alternate
  localparam logic [15:0] DAT_PORT_B  = 16'h004f; // config_data_port, alternate

  // ----------------------------------------------------------------
  // unlock / lock keys
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_ENTER   = 8'h87;
  localparam logic [7:0]  KEY_EXIT    = 8'haa;

  // ----------------------------------------------------------------
  // configuration register indices and device numbers
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_DEV     = 8'h07; // logical_device_select
  localparam logic [7:0]  IDX_WD_ACT  = 8'h30; // watchdog_activate
  localparam logic [7:0]  IDX_DIR     = 8'hf0; // port_direction
  localparam logic [7:0]  IDX_DATA    = 8'hf1; // port_data
  localparam logic [7:0]  IDX_INV     = 8'hf2; // port_invert
  localparam logic [7:0]  IDX_WD_TMO  = 8'hf6; // watchdog_timeout
  localparam logic [7:0]  DEV_GPIO    = 8'h07;
  localparam logic [7:0]  DEV_WDOG    = 8'h08;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_DEV     = 8'h00;
  localparam logic [7:0]  RST_INDEX   = 8'h00;
  localparam logic [7:0]  RST_DIR     = 8'hff;
  localparam logic [7:0]  RST_DATA    = 8'h00;
  localparam logic [7:0]  RST_INV     = 8'h00;
  localparam logic [7:0]  RST_WD_ACT  = 8'h00;
  localparam logic [7:0]  RST_WD_TMO  = 8'h00;
  localparam logic [7:0]  RD_IDLE     = 8'hff; // read value of unmapped or locked access

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned SEC_TIME    = 1;                 // watchdog tick, seconds
  localparam int unsigned SEC_CYCLES  = CLK_HZ * SEC_TIME; // default prescale count
  localparam int unsigned RST_TIME_NS = 100;               // cpu reset pulse, ns
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned RST_CYCLES  = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // configuration mode states, gray along enter path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SGW_LOCKED = 2'b00,
    SGW_ARMED  = 2'b01,
    SGW_OPEN   = 2'b11
  } sgw_mode_t;

endpackage

// >>> hdl/sgw_wdg_if.sv
// link between configuration logic and watchdog counter
`timescale 1ns/10ps
interface sgw_wdg_if;
  logic       active;   // watchdog enabled
  logic [7:0] timeout;  // bcd seconds
  logic       kick;     // one-cycle reload request
  logic       expired;  // one-cycle expiry pulse

  modport cfg (output active, output timeout, output kick, input expired);
  modport wdg (input active, input timeout, input kick, output expired);
endinterface

// >>> hdl/sgw_watchdog.sv
// watchdog counter: bcd second timeout and cpu reset pulse
`timescale 1ns/10ps
module sgw_watchdog #(
  parameter int unsigned SEC_CYC = sgw_pkg::SEC_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst,
  sgw_wdg_if.wdg      wd,
  output logic        cpu_rst
);

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  logic [31:0] pre_reg;
  logic [7:0]  secs_reg;
  logic [7:0]  pulse_reg;
  logic [7:0]  load_secs;
  logic        tick;
  logic        expire;

  // bcd timeout to binary seconds, 0x20 gives 20 s
  assign load_secs = 8'((wd.timeout[7:4] * 4'd10) + {4'h0, wd.timeout[3:0]});
  assign tick      = wd.active && (secs_reg != 8'h00) && (pre_reg == 32'(SEC_CYC - 1));
  assign expire    = tick && (secs_reg == 8'h01);
  assign wd.expired = expire;
  assign cpu_rst   = (pulse_reg != 8'h00);

  // prescaler runs only while armed; a kick restarts the whole period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg  <= 32'h0000_0000;
      secs_reg <= 8'h00;
    end else if (wd.kick || !wd.active || expire) begin
      pre_reg  <= 32'h0000_0000;
      secs_reg <= load_secs;
    end else if (tick) begin
      pre_reg  <= 32'h0000_0000;
      secs_reg <= secs_reg - 8'h01;
    end else if (secs_reg != 8'h00) begin
      pre_reg  <= pre_reg + 32'h0000_0001;
    end
  end

  // stretch expiry into a fixed-length cpu reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_reg <= 8'h00;
    end else if (expire) begin
      pulse_reg <= 8'(sgw_pkg::RST_CYCLES);
    end else if (pulse_reg != 8'h00) begin
      pulse_reg <= pulse_reg - 8'h01;
    end
  end

endmodule

// >>> hdl/sgw_top.sv
// configuration port with unlock, gpio logical device and watchdog device
`timescale 1ns/10ps
module sgw_top #(
  parameter int unsigned SEC_CYC = sgw_pkg::SEC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  input  wire logic        alt_base,
  input  wire logic [7:0]  gp_lines_in,
  output logic      [7:0]  gp_lines_out,
  output logic      [7:0]  gp_lines_oe,
  output logic             cfg_mode,
  output logic             cpu_rst
);

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  // true when the current index and device number select a register
  function automatic logic reg_sel(input logic [7:0] idx, input logic [7:0] dev,
                                   input logic [7:0] want_idx, input logic [7:0] want_dev);
    reg_sel = (idx == want_idx) && (dev == want_dev);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers, three stages, change taken when stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [8:0] s1_reg;
  logic [8:0] s2_reg;
  logic [8:0] s3_reg;
  logic [8:0] pin_reg;
  logic [8:0] pin_next;

  // raw capture chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 9'h000;
      s2_reg <= 9'h000;
      s3_reg <= 9'h000;
    end else begin
      s1_reg <= {alt_base, gp_lines_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per-bit acceptance once the two late stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_pin
      assign pin_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : pin_reg[gi];
    end
  endgenerate

  // filtered pin levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_reg <= 9'h000;
    end else begin
      pin_reg <= pin_next;
    end
  end

  // ----------------------------------------------------------------
  // port address decode
  // ----------------------------------------------------------------
  logic alt_sel;
  logic idx_hit;
  logic dat_hit;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;

  assign alt_sel = pin_reg[8];
  assign idx_hit = io_addr == (alt_sel ? sgw_pkg::IDX_PORT_B : sgw_pkg::IDX_PORT_A);
  assign dat_hit = io_addr == (alt_sel ? sgw_pkg::DAT_PORT_B : sgw_pkg::DAT_PORT_A);
  assign idx_wr  = io_wr && idx_hit;
  assign dat_wr  = io_wr && dat_hit;
  assign dat_rd  = io_rd && dat_hit;

  // ----------------------------------------------------------------
  // configuration mode sequencer
  // ----------------------------------------------------------------
  sgw_pkg::sgw_mode_t mode_reg;
  sgw_pkg::sgw_mode_t mode_next;
  logic               key_enter;

  assign key_enter = (io_wdata == sgw_pkg::KEY_ENTER);

  // two enter keys in a row open; any other index write breaks the pair
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      sgw_pkg::SGW_LOCKED: begin
        if (idx_wr && key_enter) begin
          mode_next = sgw_pkg::SGW_ARMED;
        end
      end
      sgw_pkg::SGW_ARMED: begin
        if (idx_wr) begin
          mode_next = key_enter ? sgw_pkg::SGW_OPEN : sgw_pkg::SGW_LOCKED;
        end
      end
      sgw_pkg::SGW_OPEN: begin
        if (idx_wr && (io_wdata == sgw_pkg::KEY_EXIT)) begin
          mode_next = sgw_pkg::SGW_LOCKED;
        end
      end
      default: begin
        mode_next = sgw_pkg::SGW_LOCKED;
      end
    endcase
  end

  // mode state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= sgw_pkg::SGW_LOCKED;
    end else begin
      mode_reg <= mode_next;
    end
  end

  logic is_open;
  assign is_open  = (mode_reg == sgw_pkg::SGW_OPEN);
  assign cfg_mode = is_open;

  // ----------------------------------------------------------------
  // index register
  // ----------------------------------------------------------------
  logic [7:0] index_reg;

  // index held until the next index write while open; exit key is not stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_reg <= sgw_pkg::RST_INDEX;
    end else if (idx_wr && is_open && (io_wdata != sgw_pkg::KEY_EXIT)) begin
      index_reg <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration register selects
  // ----------------------------------------------------------------
  logic [7:0] dev_reg;
  logic       cfg_wr;
  logic       sel_dev;
  logic       sel_dir;
  logic       sel_data;
  logic       sel_inv;
  logic       sel_wact;
  logic       sel_wtmo;

  assign cfg_wr   = dat_wr && is_open;
  assign sel_dev  = (index_reg == sgw_pkg::IDX_DEV);
  assign sel_dir  = reg_sel(index_reg, dev_reg, sgw_pkg::IDX_DIR, sgw_pkg::DEV_GPIO);
  assign sel_data = reg_sel(index_reg, dev_reg, sgw_pkg::IDX_DATA, sgw_pkg::DEV_GPIO);
  assign sel_inv  = reg_sel(index_reg, dev_reg, sgw_pkg::IDX_INV, sgw_pkg::DEV_GPIO);
  assign sel_wact = reg_sel(index_reg, dev_reg, sgw_pkg::IDX_WD_ACT, sgw_pkg::DEV_WDOG);
  assign sel_wtmo = reg_sel(index_reg, dev_reg, sgw_pkg::IDX_WD_TMO, sgw_pkg::DEV_WDOG);

  // per-register write enables
  logic       dev_we;
  logic       dir_we;
  logic       data_we;
  logic       inv_we;
  logic       wact_we;
  logic       wtmo_we;

  // each enable is live only for an open data port write to its own index
  assign dev_we   = cfg_wr && sel_dev;
  assign dir_we   = cfg_wr && sel_dir;
  assign data_we  = cfg_wr && sel_data;
  assign inv_we   = cfg_wr && sel_inv;
  assign wact_we  = cfg_wr && sel_wact;
  assign wtmo_we  = cfg_wr && sel_wtmo;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] dir_reg;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] inv_reg;
  logic [7:0] wact_reg;
  logic [7:0] wtmo_reg;

  // only output lines take written data; input bits keep their old value
  assign data_next = (io_wdata & ~dir_reg) | (data_reg & dir_reg);

  // logical device number
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_reg <= sgw_pkg::RST_DEV;
    end else if (dev_we) begin
      dev_reg <= io_wdata;
    end
  end

  // gpio direction, data and inversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_reg  <= sgw_pkg::RST_DIR;
      data_reg <= sgw_pkg::RST_DATA;
      inv_reg  <= sgw_pkg::RST_INV;
    end else begin
      dir_reg  <= dir_we ? io_wdata : dir_reg;
      data_reg <= data_we ? data_next : data_reg;
      inv_reg  <= inv_we ? io_wdata : inv_reg;
    end
  end

  // watchdog enable and timeout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wact_reg <= sgw_pkg::RST_WD_ACT;
      wtmo_reg <= sgw_pkg::RST_WD_TMO;
    end else begin
      wact_reg <= wact_we ? io_wdata : wact_reg;
      wtmo_reg <= wtmo_we ? io_wdata : wtmo_reg;
    end
  end

  // ----------------------------------------------------------------
  // gpio pins
  // ----------------------------------------------------------------
  logic [7:0] pin_view;

  assign gp_lines_out = data_reg ^ inv_reg;
  assign gp_lines_oe  = ~dir_reg;
  assign pin_view     = pin_reg[7:0] ^ inv_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] cfg_rdata;
  logic [7:0] gp_rdata;

  // input lines report the pin, output lines the stored data
  assign gp_rdata  = (pin_view & dir_reg) | (data_reg & ~dir_reg);
  assign cfg_rdata = sel_dev  ? dev_reg :
                     sel_dir  ? dir_reg :
                     sel_data ? gp_rdata :
                     sel_inv  ? inv_reg :
                     sel_wact ? wact_reg :
                     sel_wtmo ? wtmo_reg : sgw_pkg::RD_IDLE;

  // answer every read strobe one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata  <= sgw_pkg::RD_IDLE;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        io_rdata <= (dat_rd && is_open) ? cfg_rdata : sgw_pkg::RD_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  sgw_wdg_if wd_link ();

  assign wd_link.active  = wact_reg[0];
  assign wd_link.timeout = wtmo_reg;
  // rewriting timeout or enable services the counter
  assign wd_link.kick    = wact_we || wtmo_we;

  sgw_watchdog #(
    .SEC_CYC (SEC_CYC)
  ) sgw_watchdog_inst (
    .clk     (clk),
    .rst     (rst),
    .wd      (wd_link.wdg),
    .cpu_rst (cpu_rst)
  );

endmodule

// >>> test/sgw_host_model.sv
// host model: i/o port reads and writes into the configuration port
`timescale 1ns/10ps
module sgw_host_model (
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid
);
  // bus idle from time zero
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // write: strobe raised at a falling edge, held over one rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_wdata = ~d; // released data shows no stale value
  endtask

  // read: the answer stands in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    ok = io_rvalid;
    d = io_rdata;
  endtask

  // enter configuration mode with two back-to-back keys
  task automatic unlock(input logic [15:0] base);
    wr(base, 8'h87);
    wr(base, 8'h87);
  endtask

  // leave configuration mode
  task automatic lock(input logic [15:0] base);
    wr(base, 8'haa);
  endtask

  // register write: index first, then data
  task automatic cfg(input logic [15:0] base, input logic [7:0] idx, input logic [7:0] d);
    wr(base, idx);
    wr(base + 16'h0001, d);
  endtask
endmodule

// >>> test/sgw_checker.sv
// assertions on the ports of the configuration port block
`timescale 1ns/10ps
module sgw_checker #(
  parameter int unsigned SEC_CYC = 10
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        alt_base,
  input wire logic [7:0]  gp_lines_out,
  input wire logic [7:0]  gp_lines_oe,
  input wire logic        cfg_mode,
  input wire logic        cpu_rst
);
  logic [7:0] hi_cnt; // cycles the cpu reset has stood high
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // length of the cpu reset pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= cpu_rst ? hi_cnt + 8'h01 : 8'h00;
    end
  end

  // ----
  // port access, mode and cpu reset pulse
  // ----
  read_gets_valid_a: assert property (io_rd && io_addr == 16'h002f |=> io_rvalid)
    else $error("data port read without valid");
  valid_needs_read_a: assert property (io_rvalid |-> $past(io_rd))
    else $error("read valid without read");
  rdata_holds_a: assert property (!$past(io_rd) |-> $stable(io_rdata))
    else $error("read data moved without read");
  index_reads_ff_a: assert property (io_rd && io_addr == 16'h002e |=> io_rdata == 8'hff)
    else $error("index port read not ff");
  locked_reads_ff_a: assert property (io_rd && !cfg_mode |=> io_rdata == 8'hff)
    else $error("locked data read not ff");
  open_by_key_a: assert property ($rose(cfg_mode) |->
      $past(io_wr) && $past(io_wdata) == 8'h87)
    else $error("mode opened without key");
  close_by_key_a: assert property ($fell(cfg_mode) |->
      $past(io_wr) && $past(io_wdata) == 8'haa)
    else $error("mode closed without key");
  oe_needs_open_a: assert property ($changed(gp_lines_oe) |->
      $past(cfg_mode) && $past(io_wr))
    else $error("direction changed while locked");
  out_needs_open_a: assert property ($changed(gp_lines_out) |->
      $past(cfg_mode) && $past(io_wr))
    else $error("output changed while locked");
  pulse_length_a: assert property ($fell(cpu_rst) |-> hi_cnt == 8'h14)
    else $error("cpu reset pulse length wrong");

  cover property ($rose(cfg_mode));
  cover property ($rose(cpu_rst));
  cover property (io_rvalid && io_rdata != 8'hff);
endmodule

bind sgw_top sgw_checker #(.SEC_CYC(SEC_CYC)) sgw_checker_inst (
  .clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .alt_base(alt_base),
  .gp_lines_out(gp_lines_out), .gp_lines_oe(gp_lines_oe), .cfg_mode(cfg_mode),
  .cpu_rst(cpu_rst)
);

// >>> test/sgw_top_tb.sv
// self-checking bench for the configuration port, gpio and watchdog
`timescale 1ns/10ps
module sgw_top_tb;
  localparam int unsigned SEC_CYC = 10; // shortened watchdog tick
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        alt_base = 1'b0;
  logic [7:0]  pin_drv = 8'h00;
  logic [7:0]  gp_lines_in;
  logic [7:0]  gp_lines_out;
  logic [7:0]  gp_lines_oe;
  logic        cfg_mode;
  logic        cpu_rst;
  logic [15:0] base = 16'h002e;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n;
  logic [7:0]  rdv;
  logic        rok;

  always #2.5 clk = ~clk;
  // pads: driven lines follow the block, the rest follow the bench
  assign gp_lines_in = (gp_lines_out & gp_lines_oe) | (pin_drv & ~gp_lines_oe);

  sgw_top #(.SEC_CYC(SEC_CYC)) sgw_top_inst (.clk(clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .alt_base(alt_base), .gp_lines_in(gp_lines_in),
    .gp_lines_out(gp_lines_out), .gp_lines_oe(gp_lines_oe), .cfg_mode(cfg_mode),
    .cpu_rst(cpu_rst));
  sgw_host_model sgw_host_model_inst (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cf(input logic [7:0] idx, input logic [7:0] d);
    sgw_host_model_inst.cfg(base, idx, d);
  endtask

  // index write, then data read and compare
  task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    sgw_host_model_inst.wr(base, idx);
    sgw_host_model_inst.rd(base + 16'h0001, d, ok);
    chk(what, 8'h01, {7'h00, ok});
    chk(what, exp, d);
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("oe", 8'h00, gp_lines_oe);
    chk("out", 8'h00, gp_lines_out);
    // stray accesses while locked change nothing
    cf(8'h07, 8'h07);
    cf(8'hf0, 8'h00);
    rc("locked data", 8'hf0, 8'hff);
    chk("locked oe", 8'h00, gp_lines_oe);
    // an index write between the keys breaks the pair
    sgw_host_model_inst.wr(base, 8'h87);
    sgw_host_model_inst.wr(base, 8'h55);
    sgw_host_model_inst.wr(base, 8'h87);
    chk("mode split", 8'h00, {7'h00, cfg_mode});
    sgw_host_model_inst.wr(base, 8'h87);
    chk("mode open", 8'h01, {7'h00, cfg_mode});
    // the index port is write-only and reads back idle
    sgw_host_model_inst.rd(base, rdv, rok);
    chk("index read", 8'hff, rdv);
    // gpio device: lines 7..4 drive, 3..0 listen
    cf(8'h07, 8'h07);
    rc("dev sel", 8'h07, 8'h07);
    cf(8'hf0, 8'h0f);
    chk("oe", 8'hf0, gp_lines_oe);
    rc("dir", 8'hf0, 8'h0f);
    rc("inv reset", 8'hf2, 8'h00);
    rc("data reset", 8'hf1, 8'h00);
    pin_drv = 8'h06;
    cf(8'hf2, 8'h3c);
    cf(8'hf1, 8'ha5);
    chk("out inv", 8'h90, gp_lines_out & gp_lines_oe);
    repeat (6) @(negedge clk);
    rc("data inv", 8'hf1, 8'haa);
    cf(8'hf2, 8'h00);
    chk("out plain", 8'ha0, gp_lines_out & gp_lines_oe);
    repeat (6) @(negedge clk);
    rc("data plain", 8'hf1, 8'ha6);
    // locked again: data writes ignored
    sgw_host_model_inst.lock(base);
    chk("mode shut", 8'h00, {7'h00, cfg_mode});
    cf(8'hf1, 8'h00);
    chk("out locked", 8'ha0, gp_lines_out & gp_lines_oe);
    // watchdog: 20 ticks, expiry, then disarm
    sgw_host_model_inst.unlock(base);
    cf(8'h07, 8'h08);
    cf(8'hf6, 8'h20);
    rc("timeout", 8'hf6, 8'h20);
    cf(8'h30, 8'h01);
    repeat (150) @(negedge clk);
    chk("early reset", 8'h00, {7'h00, cpu_rst});
    n = 0;
    while (cpu_rst !== 1'b1 && n < 120) begin
      @(negedge clk);
      n++;
    end
    chk("expiry time", 8'h01, {7'h00, n >= 30 && n <= 70});
    cf(8'h30, 8'h00);
    // let the first pulse end; a missed disarm expires again inside the window
    repeat (30) @(negedge clk);
    n = 0;
    repeat (250) begin
      @(negedge clk);
      if (cpu_rst !== 1'b0) n++;
    end
    chk("disarmed", 8'h00, 8'(n));
    // alternate base: old index port no longer answers
    alt_base = 1'b1;
    repeat (6) @(negedge clk);
    sgw_host_model_inst.lock(base);
    chk("old port", 8'h01, {7'h00, cfg_mode});
    base = 16'h004e;
    rc("dev sel alt", 8'h07, 8'h08);
    // a data read with no fresh index still reaches the last indexed register
    sgw_host_model_inst.rd(base + 16'h0001, rdv, rok);
    chk("dev sel kept valid", 8'h01, {7'h00, rok});
    chk("dev sel kept", 8'h08, rdv);
    sgw_host_model_inst.lock(base);
    chk("alt shut", 8'h00, {7'h00, cfg_mode});
    give_verdict();
  end
endmodule
